/* File: core/config_word_decoder.sv */
// Contract
// RULE_01: Software copies the six-bit factory trim into the source trim field.
// RULE_02: Trim word reads zero in every bit above the six-bit field.
// RULE_03: Code-protect field 0 blocks program memory readout; 1 leaves it open.
// RULE_04: Write-protect field 0 blocks program memory writes; 1 allows them.
// RULE_05: Two-speed start runs fast RC until the chosen source is ready.
// RULE_06: Oscillator select codes map to six sources; 100 and 110 reserved.
// RULE_07: Switch mode 1x disables both, 01 switching only, 00 both enabled.
// RULE_08: Remap lock 1 allows one pin map write; 0 allows many.
// RULE_09: Pin function 1 drives clock out on second pin outside crystal modes.
// RULE_10: Primary mode codes: off, high-speed, medium-speed crystal, external clock.
// RULE_11: Watchdog config 1 keeps watchdog and its RC running, ignoring software.
// RULE_12: Watchdog config 0 lets the software bit start and stop it.
// RULE_13: Prescaler field 1 divides by 128, 0 by 32.
// RULE_14: Postscaler ratio is two to the power of the field.
// RULE_15: PLL wait field 1 holds a PLL switch until lock.
// RULE_16: Debug channel codes 11, 10, 01 pick pin pairs 1, 2, 3.
// RULE_17: All configuration reloads from the stored words on every reset.
// RULE_18: Software reads the trim from its fixed flash location first.
// RULE_19: Reserved multi-bit codes give a safe default and a fault flag.
//
// Decided for this implementation: the address map and the APB register port.
`timescale 1ns/1ns
module config_word_decoder (
	// Clock and reset
	input  wire logic         pclk,
	input  wire logic         presetn,
	// APB slave
	input  wire logic         psel,
	input  wire logic         penable,
	input  wire logic         pwrite,
	input  wire logic [7:0]   paddr,
	input  wire logic [31:0]  pwdata,
	output logic [31:0]       prdata,
	output logic              pready,
	output logic              pslverr,
	// Stored configuration words, static while powered
	input  wire logic [7:0]   nv_prot_byte,
	input  wire logic [7:0]   nv_sel_byte,
	input  wire logic [7:0]   nv_osc_byte,
	input  wire logic [7:0]   nv_wdt_byte,
	input  wire logic [7:0]   nv_dbg_byte,
	input  wire logic [23:0]  nv_trim_word,
	// Oscillator status
	input  wire logic         osc_ready,
	input  wire logic         pll_locked,
	// Configuration status
	output logic              cfg_loaded,
	output logic              cfg_fault,
	// Memory protection
	output logic              readout_protect,
	output logic              write_protect,
	// Clock settings
	output cfg_pkg::src_e     active_src,
	output cfg_pkg::src_e     target_src,
	output cfg_pkg::pri_e     pri_mode,
	output logic              clk_hold,
	output logic              switch_en,
	output logic              fail_safe_en,
	output logic              second_osc_pin_clkout,
	output logic              pll_wait,
	// Pin remap
	output logic [7:0]        pin_map,
	output logic              pin_map_locked,
	// Watchdog
	output logic              wdt_run,
	output logic              wdrc_run,
	output logic [7:0]        wdt_prescale,
	output logic [3:0]        wdt_post_exp,
	output logic [15:0]       wdt_post_ratio,
	// Debug channel, one-hot pairs 1..3
	output logic [2:0]        debug_channel,
	// Current source
	output logic              cs_enable,
	output logic [2:0]        cs_out_select,
	output logic [5:0]        source_trim_field
);
	import cfg_pkg::*;

	typedef struct packed {
		load_e       state;
		logic [7:0]  prot;
		logic [7:0]  sel;
		logic [7:0]  osc;
		logic [7:0]  wdt;
		logic [7:0]  dbg;
		logic [5:0]  trim;
		logic        cs_en;
		logic [2:0]  cs_sel;
		logic [5:0]  cs_trim;
		logic        soft_wdt;
		logic [7:0]  map;
		logic        map_done;
		logic        locked;
		logic        fault;
		logic        rd_prot;
		logic        wr_prot;
		logic [2:0]  dbg_ch;
		logic        dbg_bad;
		logic        pready;
		logic        pslverr;
		logic [31:0] prdata;
	} top_s;

	top_s st_ff;
	top_s nxt_st;

	logic        valid;
	logic        osc_bad;
	logic        access;
	logic        wr_go;
	logic        hit;
	logic [31:0] rd_val;
	logic [31:0] status_word;

	// ==========================================================
	// Clock source decode
	osc_select_decode u_osc (
		.pclk         (pclk),
		.presetn      (presetn),
		.cfg_valid    (valid),
		.sel_byte     (st_ff.sel),
		.osc_byte     (st_ff.osc),
		.pll_wait     (st_ff.wdt[PLLWAIT_BIT]),
		.osc_ready    (osc_ready),
		.pll_locked   (pll_locked),
		.active_src   (active_src),
		.target_src   (target_src),
		.pri_mode     (pri_mode),
		.clk_hold     (clk_hold),
		.switch_en    (switch_en),
		.fail_safe_en (fail_safe_en),
		.second_osc_pin_clkout  (second_osc_pin_clkout),
		.osc_code_bad (osc_bad)
	);

	// ==========================================================
	// Watchdog settings
	watchdog_setup u_wdt (
		.pclk       (pclk),
		.presetn    (presetn),
		.cfg_valid  (valid),
		.wdt_byte   (st_ff.wdt),
		.soft_en    (st_ff.soft_wdt),
		.wdt_run    (wdt_run),
		.wdrc_run   (wdrc_run),
		.prescale   (wdt_prescale),
		.post_exp   (wdt_post_exp),
		.post_ratio (wdt_post_ratio)
	);

	assign valid = (st_ff.state == ST_RUN);

	// ==========================================================
	// Read mux and decode
	always_comb begin
		status_word = 32'h0000_0000;
		status_word[0] = valid;
		status_word[1] = osc_bad;
		status_word[2] = st_ff.dbg_bad;
		status_word[3] = st_ff.rd_prot;
		status_word[4] = st_ff.wr_prot;
		status_word[5] = st_ff.locked;
		status_word[10:8] = active_src;
		status_word[13:11] = target_src;
		status_word[14] = clk_hold;
		status_word[15] = wdt_run;
		status_word[23:16] = st_ff.sel;
		status_word[31:24] = st_ff.osc;
		rd_val = 32'h0000_0000;
		hit = 1'b1;
		unique case (paddr)
			OFS_TRIM_WORD: rd_val[TRIM_HI:TRIM_LO] = st_ff.trim; // see RULE_02
			OFS_CS_CTRL: begin
				rd_val[CS_EN_BIT] = st_ff.cs_en;
				rd_val[CS_SEL_HI:CS_SEL_LO] = st_ff.cs_sel;
				rd_val[TRIM_HI:TRIM_LO] = st_ff.cs_trim;
			end
			OFS_SOFT_WDT:   rd_val[0] = st_ff.soft_wdt;
			OFS_CFG_STATUS: rd_val = status_word;
			OFS_PIN_MAP:    rd_val[7:0] = st_ff.map;
			default:        hit = 1'b0;
		endcase
	end

	// ==========================================================
	// Next state: loader, bus slave, control registers
	always_comb begin
		nxt_st = st_ff;
		access = psel && penable;
		wr_go = access && st_ff.pready && pwrite && hit;
		// Loader: one cycle after every reset release the words are taken
		unique case (st_ff.state)
			ST_LOAD: begin
				nxt_st.prot = nv_prot_byte; // see RULE_17
				nxt_st.sel = nv_sel_byte;
				nxt_st.osc = nv_osc_byte;
				nxt_st.wdt = nv_wdt_byte;
				nxt_st.dbg = nv_dbg_byte;
				nxt_st.trim = nv_trim_word[TRIM_HI:TRIM_LO];
				nxt_st.state = ST_RUN;
			end
			ST_RUN: nxt_st.state = ST_RUN;
		endcase
		// Protection stays on until the loaded words say otherwise
		nxt_st.rd_prot = !valid || !st_ff.prot[CP_BIT]; // see RULE_03
		nxt_st.wr_prot = !valid || !st_ff.prot[WP_BIT]; // see RULE_04
		// Debug pair select; reserved 00 falls back to pair 1
		nxt_st.dbg_bad = 1'b0;
		unique case (st_ff.dbg[DBGCH_HI:DBGCH_LO])
			DBG_PAIR1: nxt_st.dbg_ch = 3'h1; // see RULE_16
			DBG_PAIR2: nxt_st.dbg_ch = 3'h2;
			DBG_PAIR3: nxt_st.dbg_ch = 3'h4;
			default: begin
				nxt_st.dbg_ch = RST_DBG_CH; // see RULE_19
				nxt_st.dbg_bad = valid;
			end
		endcase
		// One wait state: ready rises in the second access cycle
		nxt_st.pready = access && !st_ff.pready;
		nxt_st.pslverr = access && !st_ff.pready && !hit;
		if (access && !st_ff.pready) begin
			nxt_st.prdata = pwrite ? 32'h0000_0000 : rd_val;
		end
		// Writes take effect at the completing edge only
		if (wr_go) begin
			unique case (paddr)
				OFS_CS_CTRL: begin
					nxt_st.cs_en = pwdata[CS_EN_BIT];
					nxt_st.cs_sel = pwdata[CS_SEL_HI:CS_SEL_LO];
					nxt_st.cs_trim = pwdata[TRIM_HI:TRIM_LO]; // see RULE_01
				end
				OFS_SOFT_WDT: nxt_st.soft_wdt = pwdata[0]; // see RULE_12
				OFS_PIN_MAP: begin
					// With the remap lock bit set, locked after the first write until the next reset
					if (!st_ff.locked) begin
						nxt_st.map = pwdata[7:0]; // see RULE_08
						nxt_st.map_done = 1'b1;
					end
				end
				default: nxt_st.map_done = st_ff.map_done;
			endcase
		end
		// Registered so the lock and fault pins come straight from flops
		nxt_st.locked = nxt_st.osc[REMAP_BIT] && nxt_st.map_done; // see RULE_08
		nxt_st.fault = nxt_st.dbg_bad || osc_bad; // see RULE_19
	end

	// State register; the soft watchdog bit clears on every reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_ff <= '{state: ST_LOAD, prot: RST_CFG_BYTE, sel: RST_CFG_BYTE, osc: RST_CFG_BYTE,
			           wdt: RST_CFG_BYTE, dbg: RST_CFG_BYTE, trim: 6'h00, cs_en: 1'b0, cs_sel: 3'h0,
			           cs_trim: 6'h00, soft_wdt: 1'b0, map: RST_PIN_MAP, map_done: 1'b0, locked: 1'b0, fault: 1'b0,
			           rd_prot: 1'b1, wr_prot: 1'b1, dbg_ch: RST_DBG_CH, dbg_bad: 1'b0,
			           pready: 1'b0, pslverr: 1'b0, prdata: 32'h0000_0000};
		end else begin
			st_ff <= nxt_st;
		end
	end

	// ==========================================================
	// Outputs
	assign prdata            = st_ff.prdata;
	assign pready            = st_ff.pready;
	assign pslverr           = st_ff.pslverr;
	assign cfg_loaded        = valid;
	assign cfg_fault         = st_ff.fault;
	assign readout_protect   = st_ff.rd_prot;
	assign write_protect     = st_ff.wr_prot;
	assign pll_wait          = st_ff.wdt[PLLWAIT_BIT];
	assign pin_map           = st_ff.map;
	assign pin_map_locked    = st_ff.locked;
	assign debug_channel     = st_ff.dbg_ch;
	assign cs_enable         = st_ff.cs_en;
	assign cs_out_select     = st_ff.cs_sel;
	assign source_trim_field = st_ff.cs_trim;

endmodule

/* File: core/cfg_pkg.sv */
package cfg_pkg;

	// ==========================================================
	// Register byte offsets
	localparam logic [7:0] OFS_TRIM_WORD  = 8'h00;
	localparam logic [7:0] OFS_CS_CTRL    = 8'h04;
	localparam logic [7:0] OFS_SOFT_WDT   = 8'h08;
	localparam logic [7:0] OFS_CFG_STATUS = 8'h0C;
	localparam logic [7:0] OFS_PIN_MAP    = 8'h10;

	// ==========================================================
	// Current source control field positions
	localparam int CS_EN_BIT   = 15;
	localparam int CS_SEL_HI   = 10;
	localparam int CS_SEL_LO   = 8;
	localparam int TRIM_HI     = 5;
	localparam int TRIM_LO     = 0;
	localparam int TRIM_W      = 6;
	localparam int TRIM_WORD_W = 24;

	// ==========================================================
	// Configuration byte field positions
	localparam int CP_BIT       = 1;
	localparam int WP_BIT       = 0;
	localparam int TWO_SPD_BIT  = 7;
	localparam int OSEL_HI      = 2;
	localparam int OSEL_LO      = 0;
	localparam int CSW_HI       = 7;
	localparam int CSW_LO       = 6;
	localparam int REMAP_BIT    = 5;
	localparam int OSC2FN_BIT   = 2;
	localparam int PMODE_HI     = 1;
	localparam int PMODE_LO     = 0;
	localparam int WDTEN_BIT    = 7;
	localparam int PLLWAIT_BIT  = 5;
	localparam int PRE_BIT      = 4;
	localparam int POST_HI      = 3;
	localparam int POST_LO      = 0;
	localparam int DBGCH_HI     = 1;
	localparam int DBGCH_LO     = 0;

	// ==========================================================
	// Field encodings
	localparam logic [2:0] FN_FIRC       = 3'h0;
	localparam logic [2:0] FN_FRCDIV_PLL = 3'h1;
	localparam logic [2:0] FN_PRI        = 3'h2;
	localparam logic [2:0] FN_PRI_PLL    = 3'h3;
	localparam logic [2:0] FN_WDRC       = 3'h5;
	localparam logic [2:0] FN_FRCDIV     = 3'h7;
	localparam logic [1:0] PM_EXT        = 2'h0;
	localparam logic [1:0] PM_MED        = 2'h1;
	localparam logic [1:0] PM_HIGH       = 2'h2;
	localparam logic [1:0] PM_OFF        = 2'h3;
	localparam logic [1:0] CSM_BOTH      = 2'h0;
	localparam logic [1:0] CSM_SWITCH    = 2'h1;
	localparam logic [1:0] DBG_PAIR1     = 2'h3;
	localparam logic [1:0] DBG_PAIR2     = 2'h2;
	localparam logic [1:0] DBG_PAIR3     = 2'h1;
	localparam logic [7:0] PRESCALE_LONG  = 8'h80;
	localparam logic [7:0] PRESCALE_SHORT = 8'h20;

	// ==========================================================
	// Values after reset
	localparam logic [7:0] RST_CFG_BYTE = 8'h00;
	localparam logic [7:0] RST_PIN_MAP  = 8'h00;
	localparam logic [2:0] RST_DBG_CH   = 3'h1;

	// ==========================================================
	// Types
	typedef enum logic [2:0] {
		SRC_FIRC,
		SRC_FRCDIV_PLL,
		SRC_PRI,
		SRC_PRI_PLL,
		SRC_WDRC,
		SRC_FRCDIV
	} src_e;

	typedef enum logic [1:0] {
		PRI_EXT,
		PRI_MED,
		PRI_HIGH,
		PRI_OFF
	} pri_e;

	typedef enum logic {
		ST_LOAD,
		ST_RUN
	} load_e;

endpackage

/* File: core/osc_select_decode.sv */
`timescale 1ns/1ns
module osc_select_decode (
	// Clock and reset
	input  wire logic         pclk,
	input  wire logic         presetn,
	// Loaded configuration
	input  wire logic         cfg_valid,
	input  wire logic [7:0]   sel_byte,
	input  wire logic [7:0]   osc_byte,
	input  wire logic         pll_wait,
	// Oscillator status
	input  wire logic         osc_ready,
	input  wire logic         pll_locked,
	// Decoded settings
	output cfg_pkg::src_e     active_src,
	output cfg_pkg::src_e     target_src,
	output cfg_pkg::pri_e     pri_mode,
	output logic              clk_hold,
	output logic              switch_en,
	output logic              fail_safe_en,
	output logic              second_osc_pin_clkout,
	output logic              osc_code_bad
);
	import cfg_pkg::*;

	typedef struct packed {
		src_e active;
		src_e target;
		pri_e pri;
		logic hold;
		logic sw_en;
		logic fs_en;
		logic clkout;
		logic bad;
	} osc_s;

	osc_s st_ff;
	osc_s nxt_st;
	logic [2:0] fn;
	logic [1:0] pm;
	logic       pll_src;
	logic       ready;

	// ==========================================================
	// Decode
	always_comb begin
		nxt_st = st_ff;
		fn = sel_byte[OSEL_HI:OSEL_LO];
		pm = osc_byte[PMODE_HI:PMODE_LO];
		nxt_st.bad = 1'b0;
		// Reserved codes fall back to the fast RC, always present
		unique case (fn)
			FN_FIRC:       nxt_st.target = SRC_FIRC; // see RULE_06
			FN_FRCDIV_PLL: nxt_st.target = SRC_FRCDIV_PLL;
			FN_PRI:        nxt_st.target = SRC_PRI;
			FN_PRI_PLL:    nxt_st.target = SRC_PRI_PLL;
			FN_WDRC:       nxt_st.target = SRC_WDRC;
			FN_FRCDIV:     nxt_st.target = SRC_FRCDIV;
			default: begin
				nxt_st.target = SRC_FIRC; // see RULE_19
				nxt_st.bad = 1'b1;
			end
		endcase
		unique case (pm)
			PM_EXT: nxt_st.pri = PRI_EXT; // see RULE_10
			PM_MED:  nxt_st.pri = PRI_MED;
			PM_HIGH: nxt_st.pri = PRI_HIGH;
			PM_OFF: nxt_st.pri = PRI_OFF;
		endcase
		// Switching and monitor; 1x turns both off
		nxt_st.sw_en = ~osc_byte[CSW_HI]; // see RULE_07
		nxt_st.fs_en = (osc_byte[CSW_HI:CSW_LO] == CSM_BOTH);
		// Crystal modes own the second pin
		nxt_st.clkout = osc_byte[OSC2FN_BIT] && (pm != PM_MED) && (pm != PM_HIGH); // see RULE_09
		// PLL sources wait for lock only when asked to
		pll_src = (nxt_st.target == SRC_FRCDIV_PLL) || (nxt_st.target == SRC_PRI_PLL);
		ready = osc_ready && (!pll_src || !pll_wait || pll_locked); // see RULE_15
		if (sel_byte[TWO_SPD_BIT] && !ready) begin
			nxt_st.active = SRC_FIRC; // see RULE_05
			nxt_st.hold = 1'b0;
		end else begin
			nxt_st.active = nxt_st.target;
			nxt_st.hold = !ready;
		end
		if (!cfg_valid) begin
			nxt_st.active = SRC_FIRC;
			nxt_st.hold = 1'b1;
			nxt_st.bad = 1'b0;
		end
	end

	// State register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_ff <= '{active: SRC_FIRC, target: SRC_FIRC, pri: PRI_OFF, hold: 1'b1,
			           sw_en: 1'b0, fs_en: 1'b0, clkout: 1'b0, bad: 1'b0};
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign active_src   = st_ff.active;
	assign target_src   = st_ff.target;
	assign pri_mode     = st_ff.pri;
	assign clk_hold     = st_ff.hold;
	assign switch_en    = st_ff.sw_en;
	assign fail_safe_en = st_ff.fs_en;
	assign second_osc_pin_clkout  = st_ff.clkout;
	assign osc_code_bad = st_ff.bad;

endmodule

/* File: core/watchdog_setup.sv */
`timescale 1ns/1ns
module watchdog_setup (
	// Clock and reset
	input  wire logic         pclk,
	input  wire logic         presetn,
	// Configuration and software control
	input  wire logic         cfg_valid,
	input  wire logic [7:0]   wdt_byte,
	input  wire logic         soft_en,
	// Watchdog settings
	output logic              wdt_run,
	output logic              wdrc_run,
	output logic [7:0]        prescale,
	output logic [3:0]        post_exp,
	output logic [15:0]       post_ratio
);
	import cfg_pkg::*;

	typedef struct packed {
		logic        run;
		logic        wdrc;
		logic [7:0]  pre;
		logic [3:0]  exp;
		logic [15:0] ratio;
	} wdt_s;

	wdt_s st_ff;
	wdt_s nxt_st;

	// ==========================================================
	// Settings follow the loaded byte every cycle
	always_comb begin
		nxt_st = st_ff;
		// Forced-on ignores the software bit entirely
		nxt_st.run = cfg_valid && (wdt_byte[WDTEN_BIT] || soft_en); // see RULE_11 see RULE_12
		nxt_st.wdrc = nxt_st.run;
		nxt_st.pre = wdt_byte[PRE_BIT] ? PRESCALE_LONG : PRESCALE_SHORT; // see RULE_13
		nxt_st.exp = wdt_byte[POST_HI:POST_LO];
		nxt_st.ratio = 16'h0001 << nxt_st.exp; // see RULE_14
	end

	// State register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_ff <= '{run: 1'b0, wdrc: 1'b0, pre: PRESCALE_SHORT, exp: 4'h0, ratio: 16'h0001};
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign wdt_run    = st_ff.run;
	assign wdrc_run   = st_ff.wdrc;
	assign prescale   = st_ff.pre;
	assign post_exp   = st_ff.exp;
	assign post_ratio = st_ff.ratio;

endmodule

/* File: verification/config_word_decoder_checker.sv */
`timescale 1ns/1ns
module config_word_decoder_checker (
	// Clock and reset
	input wire logic        pclk,
	input wire logic        presetn,
	// Bus
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	// Stored words and status
	input wire logic [7:0]  nv_prot_byte,
	input wire logic [7:0]  nv_sel_byte,
	input wire logic [7:0]  nv_wdt_byte,
	input wire logic [7:0]  nv_dbg_byte,
	input wire logic [23:0] nv_trim_word,
	input wire logic        osc_ready,
	// Decoded settings
	input wire logic        readout_protect,
	input wire logic        write_protect,
	input cfg_pkg::src_e    active_src,
	input wire logic [7:0]  pin_map,
	input wire logic        pin_map_locked,
	input wire logic        wdt_run,
	input wire logic        wdrc_run,
	input wire logic [7:0]  wdt_prescale,
	input wire logic [15:0] wdt_post_ratio,
	input wire logic [2:0]  debug_channel
);
	import cfg_pkg::*;

	// ==========================================================
	// Settle counter: decoded outputs lag the release by two edges, cfg_fault by three
	logic [2:0] up_ff;
	logic       settled;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			up_ff <= 3'h0;
		else if (up_ff != 3'h7)
			up_ff <= up_ff + 3'h1;
	end
	assign settled = (up_ff == 3'h7);

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	// ==========================================================
	// Bus steps
	sequence soft_wdt_write(logic v);
		psel && penable && pready && pwrite && paddr == OFS_SOFT_WDT && pwdata[0] == v;
	endsequence
	sequence trim_read_done;
		psel && penable && pready && !pwrite && paddr == OFS_TRIM_WORD;
	endsequence

	// ==========================================================
	// Decode relations
	chk_read_protect: assert property (settled |-> readout_protect == !nv_prot_byte[CP_BIT])
		else $error("readout protect does not follow its field");
	chk_write_protect: assert property (settled |-> write_protect == !nv_prot_byte[WP_BIT])
		else $error("write protect does not follow its field");
	chk_two_speed: assert property (settled && nv_sel_byte[TWO_SPD_BIT] && !$past(osc_ready) &&
		!$past(osc_ready, 2) |-> active_src == SRC_FIRC) else $error("two-speed start left fast RC early");
	chk_wdt_forced: assert property (settled && nv_wdt_byte[WDTEN_BIT] |-> wdt_run && wdrc_run)
		else $error("forced watchdog not running");
	chk_soft_stop: assert property (settled && !nv_wdt_byte[WDTEN_BIT] ##0 soft_wdt_write(1'h0)
		|-> ##2 !wdt_run && !wdrc_run) else $error("software stop of watchdog ignored");
	chk_prescale_ratio: assert property (settled |-> wdt_prescale ==
		(nv_wdt_byte[PRE_BIT] ? PRESCALE_LONG : PRESCALE_SHORT)) else $error("prescaler wrong");
	chk_post_ratio: assert property (settled |-> wdt_post_ratio == 16'h1 << nv_wdt_byte[3:0])
		else $error("postscaler ratio wrong");
	chk_debug_pair: assert property (settled |-> debug_channel == (nv_dbg_byte[1:0] == 2'h2 ? 3'h2 :
		nv_dbg_byte[1:0] == 2'h1 ? 3'h4 : 3'h1)) else $error("debug pair wrong");
	chk_lock_hold: assert property (pin_map_locked |=> $stable(pin_map))
		else $error("locked pin map changed");
	chk_trim_read: assert property (trim_read_done |-> prdata == {26'h0, nv_trim_word[5:0]})
		else $error("trim word read wrong");
endmodule

bind config_word_decoder config_word_decoder_checker u_chk (.pclk, .presetn, .psel, .penable, .pwrite,
	.paddr, .pwdata, .prdata, .pready, .nv_prot_byte, .nv_sel_byte, .nv_wdt_byte, .nv_dbg_byte,
	.nv_trim_word, .osc_ready, .readout_protect, .write_protect, .active_src, .pin_map, .pin_map_locked,
	.wdt_run, .wdrc_run, .wdt_prescale, .wdt_post_ratio, .debug_channel);

/* File: verification/config_word_decoder_tb_top.sv */
`timescale 1ns/1ns
module config_word_decoder_tb_top;
	import cfg_pkg::*;

	// ==========================================================
	// Stimulus given a value at time zero; er, rd, b and prdata start unset
	logic        pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
	logic        osc_ready = 1'h1, pll_locked = 1'h0, er;
	logic [7:0]  paddr = 8'h00, nv_prot_byte = 8'h00, nv_sel_byte = 8'h00, nv_osc_byte = 8'h00;
	logic [7:0]  nv_wdt_byte = 8'h00, nv_dbg_byte = 8'h00;
	logic [23:0] nv_trim_word = 24'h0;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic [2:0]  b;
	// Design outputs
	logic        pready, pslverr, cfg_loaded, cfg_fault, readout_protect, write_protect, clk_hold;
	logic        switch_en, fail_safe_en, second_osc_pin_clkout, pll_wait, pin_map_locked, wdt_run, wdrc_run, cs_enable;
	src_e        active_src, target_src;
	pri_e        pri_mode;
	logic [7:0]  pin_map, wdt_prescale;
	logic [3:0]  wdt_post_exp;
	logic [15:0] wdt_post_ratio;
	logic [2:0]  debug_channel, cs_out_select;
	logic [5:0]  source_trim_field;
	int          err_count = 0, comparisons = 0, cycles = 0;
	src_e        exp_src [8] = '{SRC_FIRC, SRC_FRCDIV_PLL, SRC_PRI, SRC_PRI_PLL, SRC_FIRC, SRC_WDRC, SRC_FIRC,
		SRC_FRCDIV};
	logic [2:0]  exp_dbg [4] = '{3'h1, 3'h4, 3'h2, 3'h1};

	config_word_decoder DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .nv_prot_byte, .nv_sel_byte, .nv_osc_byte, .nv_wdt_byte, .nv_dbg_byte, .nv_trim_word,
		.osc_ready, .pll_locked, .cfg_loaded, .cfg_fault, .readout_protect, .write_protect, .active_src,
		.target_src, .pri_mode, .clk_hold, .switch_en, .fail_safe_en, .second_osc_pin_clkout, .pll_wait, .pin_map,
		.pin_map_locked, .wdt_run, .wdrc_run, .wdt_prescale, .wdt_post_exp, .wdt_post_ratio, .debug_channel,
		.cs_enable, .cs_out_select, .source_trim_field);

	// ==========================================================
	// Clock and hang guard; a full run needs well under a thousand cycles
	always #5 pclk = ~pclk;
	always @(posedge pclk) begin
		cycles++;
		if (cycles == 5000) begin
			err_count++;
			close_out();
		end
	end

	// ==========================================================
	// Shared tasks
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			err_count++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// Stored words only change under reset, as on a real power-up
	task automatic boot(input logic [7:0] p, s, o, w, d, input logic [23:0] t);
		@(posedge pclk);
		presetn <= 1'h0;
		nv_prot_byte <= p;
		nv_sel_byte <= s;
		nv_osc_byte <= o;
		nv_wdt_byte <= w;
		nv_dbg_byte <= d;
		nv_trim_word <= t;
		repeat (4) @(posedge pclk);
		presetn <= 1'h1;
		repeat (8) @(posedge pclk);
	endtask

	// Request held until pready is seen high at a rising edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'h1;
		penable <= 1'h0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'h1 && n < 50);
		r = prdata;
		e = pslverr;
		if (n == 50)
			check(32'h0, 32'h1);
		psel <= 1'h0;
		penable <= 1'h0;
	endtask

	task automatic close_out();
		$display("comparisons=%0d mismatches=%0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// ==========================================================
	// Test sequence
	initial begin
		// Every select, mode and channel code through a fresh load each
		for (int i = 0; i < 8; i++) begin
			b = 3'(i);
			boot({6'h0, b[1:0]}, {5'h0, b}, {b[1:0], b[2], 2'h0, b[0], b[1:0]},
				{b[0], 1'h0, b[1], b[2], b, b[0]}, {6'h0, b[1:0]}, {18'h2AAAA, b, b});
			check(readout_protect, !b[1]);
			check(write_protect, !b[0]);
			check(target_src, exp_src[i]);
			check(active_src, exp_src[i]);
			check(cfg_fault, i == 4 || i == 6 || b[1:0] == 2'h0);
			check(switch_en, !b[1]);
			check(fail_safe_en, b[1:0] == 2'h0);
			check(pri_mode, b[1:0]);
			check(second_osc_pin_clkout, b[0] && b[1]);
			check({wdt_run, wdrc_run}, {b[0], b[0]});
			check(wdt_prescale, b[2] ? PRESCALE_LONG : PRESCALE_SHORT);
			check(wdt_post_ratio, 32'h1 << {b, b[0]});
			check(debug_channel, exp_dbg[b[1:0]]);
			check(clk_hold, i == 3);
			check(pll_wait, b[1]);
			check(wdt_post_exp, {b, b[0]});
			check(cfg_loaded, 1'h1);
			apb(1'h0, OFS_TRIM_WORD, 32'h0, rd, er);
			check(rd, {26'h0, b, b});
		end
		$display("decode table done");
		// Two-speed start waits for the chosen source
		osc_ready <= 1'h0;
		boot(8'h03, 8'h82, 8'h03, 8'h00, 8'h03, 24'hFFFFED);
		check(active_src, SRC_FIRC);
		check(target_src, SRC_PRI);
		osc_ready <= 1'h1;
		repeat (3) @(posedge pclk);
		check(active_src, SRC_PRI);
		// Switch to a PLL source held until lock
		boot(8'h03, 8'h03, 8'h03, 8'h20, 8'h03, 24'hFFFFED);
		check(clk_hold, 1'h1);
		pll_locked <= 1'h1;
		repeat (3) @(posedge pclk);
		check(clk_hold, 1'h0);
		$display("start-up done");
		// Software copies the trim; read-only and unmapped places
		apb(1'h0, OFS_TRIM_WORD, 32'h0, rd, er);
		apb(1'h1, OFS_CS_CTRL, 32'hFFFFFF00 | rd, rd, er);
		apb(1'h0, OFS_CS_CTRL, 32'h0, rd, er);
		check(rd, 32'h0000872D);
		check({cs_enable, cs_out_select, source_trim_field}, {1'h1, 3'h7, 6'h2D});
		apb(1'h1, OFS_TRIM_WORD, 32'hFFFFFFFF, rd, er);
		check(er, 1'h0);
		apb(1'h0, OFS_TRIM_WORD, 32'h0, rd, er);
		check(rd, 32'h0000002D);
		apb(1'h0, 8'h40, 32'h0, rd, er);
		check({er, rd}, {1'h1, 32'h0});
		$display("register access done");
		// Software watchdog control, then forced by configuration
		apb(1'h1, OFS_SOFT_WDT, 32'h1, rd, er);
		repeat (3) @(posedge pclk);
		check({wdt_run, wdrc_run}, 2'h3);
		apb(1'h1, OFS_SOFT_WDT, 32'h0, rd, er);
		repeat (3) @(posedge pclk);
		check({wdt_run, wdrc_run}, 2'h0);
		boot(8'h03, 8'h00, 8'h20, 8'hA0, 8'h03, 24'h0);
		apb(1'h0, OFS_SOFT_WDT, 32'h0, rd, er);
		check(rd, 32'h0);
		apb(1'h1, OFS_SOFT_WDT, 32'h0, rd, er);
		repeat (3) @(posedge pclk);
		check({wdt_run, wdrc_run}, 2'h3);
		$display("watchdog done");
		// Pin map: one write when locked, many when not
		for (int k = 0; k < 2; k++) begin
			if (k == 1)
				boot(8'h03, 8'h00, 8'h00, 8'h00, 8'h03, 24'h0);
			apb(1'h1, OFS_PIN_MAP, 32'h5A, rd, er);
			apb(1'h1, OFS_PIN_MAP, 32'hA5, rd, er);
			apb(1'h0, OFS_PIN_MAP, 32'h0, rd, er);
			check(rd, k == 0 ? 32'h5A : 32'hA5);
			check(pin_map_locked, k == 0);
		end
		$display("pin map done");
		close_out();
	end
endmodule
